// [bbr_cfg.svh]
`ifndef BBR_CFG_SVH
`define BBR_CFG_SVH

`define BBR_OFS_B2_MODE   8'h38
`define BBR_OFS_B2_CONF   8'h39
`define BBR_OFS_B3_VOLT   8'h3C
`define BBR_OFS_B3_STBY   8'h3D
`define BBR_OFS_B3_SLP    8'h3E
`define BBR_OFS_B3_MODE   8'h3F
`define BBR_OFS_B3_CONF   8'h40
`define BBR_OFS_BST_CTL   8'h66

`define BBR_MASK_MODE     8'h2F
`define BBR_MASK_CONF     8'h7D
`define BBR_MASK_VOLT     8'h1F
`define BBR_MASK_BST      8'h6F

`define BBR_OTP_MODE      8'h0F
`define BBR_OTP_CONF      8'h4D
`define BBR_OTP_VOLT      8'h1F
`define BBR_OTP_BST       8'h6F

`define BBR_OMODE_BIT     5
`define BBR_DVS_BIT       6
`define BBR_PHASE_LSB     4
`define BBR_FREQ_LSB      2
`define BBR_ILIM_BIT      0
`define BBR_BST_STBY_LSB  5
`define BBR_BST_NORM_LSB  2
`define BBR_BST_VOLT_LSB  0

`define BBR_CLK_NS        50
`define BBR_DVS_FAST_NS   2000
`define BBR_DVS_SLOW_NS   4000
`define BBR_DVS_FAST_CYC  (`BBR_DVS_FAST_NS / `BBR_CLK_NS)
`define BBR_DVS_SLOW_CYC  (`BBR_DVS_SLOW_NS / `BBR_CLK_NS)

`endif

// [bbr_pkg.sv]
package bbr_pkg;

    typedef enum logic [1:0] {
        BST_OFF  = 2'h0,
        BST_PFM  = 2'h1,
        BST_AUTO = 2'h2,
        BST_SKIP = 2'h3
    } bbr_bst_mode_e;

    typedef enum logic [2:0] {
        RUN_OFF = 3'h1,
        RUN_PFM = 3'h2,
        RUN_SKIP = 3'h4
    } bbr_bst_run_e;

endpackage : bbr_pkg

// [bbr_ctrl_regs.sv]
`timescale 1ns/1ns
`include "bbr_cfg.svh"

module bbr_ctrl_regs
    import bbr_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic       clk_en,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            reg_rd_ack,
    output logic            reg_addr_err,
    input  wire logic [7:0] otp_b2_mode,
    input  wire logic [7:0] otp_b2_conf,
    input  wire logic [7:0] otp_b3_volt,
    input  wire logic [7:0] otp_b3_stby,
    input  wire logic [7:0] otp_b3_slp,
    input  wire logic [7:0] otp_b3_mode,
    input  wire logic [7:0] otp_b3_conf,
    input  wire logic [7:0] otp_bst_ctl,
    input  wire logic       turn_off_evt,
    input  wire logic       turn_on_evt,
    input  wire logic       standby_req,
    input  wire logic       boost_seq_en,
    input  wire logic       boost_heavy_load,
    output logic            buck_two_off_behaviour,
    output logic      [3:0] buck_two_switch_mode,
    output logic            buck_two_scaling_rate,
    output logic      [1:0] buck_two_phase_sel,
    output logic      [1:0] buck_two_freq_sel,
    output logic            buck_two_current_limit,
    output logic            buck_three_off_behaviour,
    output logic      [3:0] buck_three_switch_mode,
    output logic            buck_three_scaling_rate,
    output logic      [1:0] buck_three_phase_sel,
    output logic      [1:0] buck_three_freq_sel,
    output logic            buck_three_current_limit,
    output logic      [4:0] buck_three_vcode,
    output logic      [1:0] buck_sleep,
    output logic      [1:0] buck_off,
    output logic      [1:0] dvs_step,
    output logic      [1:0] boost_standby_mode,
    output logic      [1:0] boost_normal_mode,
    output logic      [1:0] boost_voltage_sel,
    output bbr_bst_run_e    boost_drive
);

    localparam int FAST_CYC = `BBR_DVS_FAST_CYC;
    localparam int SLOW_CYC = `BBR_DVS_SLOW_CYC;

    logic [7:0] b2_mode_r;
    logic [7:0] b2_conf_r;
    logic [7:0] b3_volt_r;
    logic [7:0] b3_stby_r;
    logic [7:0] b3_slp_r;
    logic [7:0] b3_mode_r;
    logic [7:0] b3_conf_r;
    logic [7:0] bst_ctl_r;
    logic [7:0] rd_mux;
    logic       hit;
    logic       wr;
    logic [1:0] omode;
    logic [1:0] rate;
    logic [4:0] b3_target;
    bbr_bst_mode_e eff_mode;
    bbr_bst_run_e  drive_nxt;

    assign wr = clk_en && reg_wr;

    always_comb
    begin
        rd_mux = 8'h00;
        hit    = 1'b1;
        if (reg_addr == `BBR_OFS_B2_MODE)
            rd_mux = b2_mode_r;
        else if (reg_addr == `BBR_OFS_B2_CONF)
            rd_mux = b2_conf_r;
        else if (reg_addr == `BBR_OFS_B3_VOLT)
            rd_mux = b3_volt_r;
        else if (reg_addr == `BBR_OFS_B3_STBY)
            rd_mux = b3_stby_r;
        else if (reg_addr == `BBR_OFS_B3_SLP)
            rd_mux = b3_slp_r;
        else if (reg_addr == `BBR_OFS_B3_MODE)
            rd_mux = b3_mode_r;
        else if (reg_addr == `BBR_OFS_B3_CONF)
            rd_mux = b3_conf_r;
        else if (reg_addr == `BBR_OFS_BST_CTL)
            rd_mux = bst_ctl_r;
        else
            hit = 1'b0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            b2_mode_r <= otp_b2_mode & `BBR_OTP_MODE;
            b2_conf_r <= otp_b2_conf & `BBR_OTP_CONF;
            b3_volt_r <= otp_b3_volt & `BBR_OTP_VOLT;
            b3_stby_r <= otp_b3_stby & `BBR_OTP_VOLT;
            b3_slp_r  <= otp_b3_slp  & `BBR_OTP_VOLT;
            b3_mode_r <= otp_b3_mode & `BBR_OTP_MODE;
            b3_conf_r <= otp_b3_conf & `BBR_OTP_CONF;
            bst_ctl_r <= otp_bst_ctl & `BBR_OTP_BST;
        end
        else if (wr)
        begin
            if (reg_addr == `BBR_OFS_B2_MODE)
                b2_mode_r <= reg_wdata & `BBR_MASK_MODE;
            else if (reg_addr == `BBR_OFS_B2_CONF)
                b2_conf_r <= reg_wdata & `BBR_MASK_CONF;
            else if (reg_addr == `BBR_OFS_B3_VOLT)
                b3_volt_r <= reg_wdata & `BBR_MASK_VOLT;
            else if (reg_addr == `BBR_OFS_B3_STBY)
                b3_stby_r <= reg_wdata & `BBR_MASK_VOLT;
            else if (reg_addr == `BBR_OFS_B3_SLP)
                b3_slp_r  <= reg_wdata & `BBR_MASK_VOLT;
            else if (reg_addr == `BBR_OFS_B3_MODE)
                b3_mode_r <= reg_wdata & `BBR_MASK_MODE;
            else if (reg_addr == `BBR_OFS_B3_CONF)
                b3_conf_r <= reg_wdata & `BBR_MASK_CONF;
            else if (reg_addr == `BBR_OFS_BST_CTL)
                bst_ctl_r <= reg_wdata & `BBR_MASK_BST;
        end
    end

    // Read answer one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            reg_rdata    <= 8'h00;
            reg_rd_ack   <= 1'b0;
            reg_addr_err <= 1'b0;
        end
        else if (clk_en)
        begin
            reg_rd_ack   <= reg_rd;
            reg_addr_err <= (reg_rd || reg_wr) && !hit;
            if (reg_rd)
                reg_rdata <= rd_mux;
        end
    end

    // Field views are plain slices of the registers
    // direct field outputs
    assign buck_two_switch_mode     = b2_mode_r[3:0];
    assign buck_two_off_behaviour   = b2_mode_r[`BBR_OMODE_BIT];
    assign buck_two_scaling_rate    = b2_conf_r[`BBR_DVS_BIT];
    assign buck_two_phase_sel       = b2_conf_r[`BBR_PHASE_LSB +: 2];
    assign buck_two_freq_sel        = b2_conf_r[`BBR_FREQ_LSB +: 2];
    assign buck_two_current_limit   = b2_conf_r[`BBR_ILIM_BIT];
    assign buck_three_switch_mode   = b3_mode_r[3:0];
    assign buck_three_off_behaviour = b3_mode_r[`BBR_OMODE_BIT];
    assign buck_three_scaling_rate  = b3_conf_r[`BBR_DVS_BIT];
    assign buck_three_phase_sel     = b3_conf_r[`BBR_PHASE_LSB +: 2];
    assign buck_three_freq_sel      = b3_conf_r[`BBR_FREQ_LSB +: 2];
    assign buck_three_current_limit = b3_conf_r[`BBR_ILIM_BIT];
    assign boost_standby_mode = bst_ctl_r[`BBR_BST_STBY_LSB +: 2];
    assign boost_normal_mode  = bst_ctl_r[`BBR_BST_NORM_LSB +: 2];
    assign boost_voltage_sel  = bst_ctl_r[`BBR_BST_VOLT_LSB +: 2];

    assign omode = {b3_mode_r[`BBR_OMODE_BIT], b2_mode_r[`BBR_OMODE_BIT]};
    assign rate  = {b3_conf_r[`BBR_DVS_BIT], b2_conf_r[`BBR_DVS_BIT]};

    // Per-buck off state and voltage-scaling step timer
    genvar i;
    generate
        for (i = 0; i < 2; i++)
        begin : g_buck
            logic [6:0] cnt_r;

            always_ff @(posedge clk_sys)
            begin
                if (reset)
                begin
                    buck_sleep[i] <= 1'b0;
                    buck_off[i]   <= 1'b0;
                end
                else if (clk_en && turn_off_evt)
                begin
                    buck_sleep[i] <= omode[i];
                    buck_off[i]   <= !omode[i];
                end
                else if (clk_en && turn_on_evt)
                begin
                    buck_sleep[i] <= 1'b0;
                    buck_off[i]   <= 1'b0;
                end
            end

            always_ff @(posedge clk_sys)
            begin
                if (reset)
                begin
                    cnt_r       <= 7'h00;
                    dvs_step[i] <= 1'b0;
                end
                else if (clk_en)
                begin
                    dvs_step[i] <= (cnt_r == 7'h00);
                    if (cnt_r == 7'h00)
                        cnt_r <= rate[i] ? 7'(SLOW_CYC - 1) : 7'(FAST_CYC - 1);
                    else
                        cnt_r <= cnt_r - 7'h01;
                end
            end
        end
    endgenerate

    assign b3_target = buck_sleep[1] ? b3_slp_r[4:0] :
                       standby_req   ? b3_stby_r[4:0] : b3_volt_r[4:0];

    // Output walks one code per step so the rail ramps at the set rate
    // ramp at rate
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            buck_three_vcode <= otp_b3_volt[4:0];
        else if (clk_en && dvs_step[1] && !buck_off[1])
        begin
            if (buck_three_vcode < b3_target)
                buck_three_vcode <= buck_three_vcode + 5'h01;
            else if (buck_three_vcode > b3_target)
                buck_three_vcode <= buck_three_vcode - 5'h01;
        end
    end

    assign eff_mode = bbr_bst_mode_e'(standby_req ? boost_standby_mode
                                                  : boost_normal_mode);

    always_comb
    begin
        case (eff_mode)
            BST_PFM:  drive_nxt = RUN_PFM;
            BST_SKIP: drive_nxt = RUN_SKIP;
            BST_AUTO: drive_nxt = !boost_seq_en ? RUN_OFF :
                                  boost_heavy_load ? RUN_SKIP : RUN_PFM;
            default:  drive_nxt = RUN_OFF;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            boost_drive <= RUN_OFF;
        else if (clk_en)
            boost_drive <= drive_nxt;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_b2_mode_wr;
        (wr && reg_addr == `BBR_OFS_B2_MODE)
            |=> buck_two_switch_mode == $past(reg_wdata[3:0])
                && buck_two_off_behaviour == $past(reg_wdata[5]);
    endproperty
    a_b2_mode_wr: assert property (p_b2_mode_wr)
        else $error("buck two mode write not taken");

    property p_rsv_zero;
        (clk_en && reg_rd && reg_addr == `BBR_OFS_B2_CONF)
            |=> reg_rd_ack && reg_rdata[7] == 1'b0 && reg_rdata[1] == 1'b0;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero)
        else $error("reserved config bits read nonzero");

    property p_b2_sleep;
        (clk_en && turn_off_evt && omode[0]) |=> buck_sleep[0] && !buck_off[0];
    endproperty
    a_b2_sleep: assert property (p_b2_sleep)
        else $error("buck two did not enter sleep");

    property p_b3_off;
        (clk_en && turn_off_evt && !omode[1]) |=> buck_off[1] && !buck_sleep[1];
    endproperty
    a_b3_off: assert property (p_b3_off)
        else $error("buck three did not turn off");

    property p_fast_gap;
        (clk_en && $rose(dvs_step[0]) && !rate[0])[*1] ##1 clk_en[*8]
            |-> !dvs_step[0];
    endproperty
    a_fast_gap: assert property (p_fast_gap)
        else $error("buck two step came too early");

    property p_ramp_step;
        $changed(buck_three_vcode) |-> $past(dvs_step[1]) && $past(clk_en);
    endproperty
    a_ramp_step: assert property (p_ramp_step)
        else $error("buck three code moved without a step");

    property p_auto_gate;
        (clk_en && eff_mode == BST_AUTO && !boost_seq_en)
            |=> boost_drive == RUN_OFF;
    endproperty
    a_auto_gate: assert property (p_auto_gate)
        else $error("boost ran auto without start-up enable");

    property p_auto_load;
        (clk_en && eff_mode == BST_AUTO && boost_seq_en)
            |=> boost_drive == ($past(boost_heavy_load) ? RUN_SKIP : RUN_PFM);
    endproperty
    a_auto_load: assert property (p_auto_load)
        else $error("boost auto choice wrong for load");

    property p_bst_wr;
        (wr && reg_addr == `BBR_OFS_BST_CTL)
            |=> boost_voltage_sel == $past(reg_wdata[1:0])
                && bst_ctl_r[4] == 1'b0 && bst_ctl_r[7] == 1'b0;
    endproperty
    a_bst_wr: assert property (p_bst_wr)
        else $error("boost control write wrong");

    property p_otp_load;
        $fell(reset) |-> buck_two_switch_mode == $past(otp_b2_mode[3:0])
                         && !buck_two_off_behaviour;
    endproperty
    a_otp_load: assert property (p_otp_load)
        else $error("buck two mode not loaded from otp");

endmodule : bbr_ctrl_regs

// [bbr_host_model.sv]
`timescale 1ns/1ns

module bbr_host_model
(
    input  wire logic       clk_sys,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rd_ack,
    input  wire logic       reg_addr_err
);
    initial
    begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end

    // Released lines show the inverse so a stale address or data is never mistaken for valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask : wr

    // One taking edge per read; the ack stands for one cycle after it, the data holds until the next read
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic e, output logic k);
        @(negedge clk_sys);
        reg_rd   = 1'b1;
        reg_addr = a;
        @(negedge clk_sys);
        reg_rd   = 1'b0;
        reg_addr = ~a;
        k        = reg_rd_ack;
        d        = reg_rdata;
        e        = reg_addr_err;
    endtask : rd
endmodule : bbr_host_model

// [test_buck_boost_regulator_ctrl_regs.sv]
`timescale 1ns/1ns

module test_buck_boost_regulator_ctrl_regs
    import bbr_pkg::*;
;
    logic         clk_sys, reset, clk_en, turn_off_evt, turn_on_evt, standby_req;
    logic         boost_seq_en, boost_heavy_load, reg_wr, reg_rd, reg_rd_ack, reg_addr_err;
    logic         buck_two_off_behaviour, buck_two_scaling_rate, buck_two_current_limit;
    logic         buck_three_off_behaviour, buck_three_scaling_rate, buck_three_current_limit;
    logic   [7:0] reg_addr, reg_wdata, reg_rdata, rd_d;
    logic   [3:0] buck_two_switch_mode, buck_three_switch_mode;
    logic   [1:0] buck_two_phase_sel, buck_two_freq_sel, buck_three_phase_sel;
    logic   [1:0] buck_three_freq_sel, buck_sleep, buck_off, dvs_step;
    logic   [1:0] boost_standby_mode, boost_normal_mode, boost_voltage_sel;
    logic   [4:0] buck_three_vcode;
    bbr_bst_run_e boost_drive;
    logic   [7:0] otp_v [8];
    logic   [7:0] sh [8];
    logic   [7:0] ofs [8] = '{8'h38, 8'h39, 8'h3C, 8'h3D, 8'h3E, 8'h3F, 8'h40, 8'h66};
    logic   [7:0] msk [8] = '{8'h2F, 8'h7D, 8'h1F, 8'h1F, 8'h1F, 8'h2F, 8'h7D, 8'h6F};
    logic   [7:0] om [8]  = '{8'h0F, 8'h4D, 8'h1F, 8'h1F, 8'h1F, 8'h0F, 8'h4D, 8'h6F};
    logic  [31:0] seed;
    logic         rd_e, rd_k;
    int           err_total, checks, t;
    wire    [7:0] b2_mode = {2'h0, buck_two_off_behaviour, 1'h0, buck_two_switch_mode};
    wire    [7:0] b3_mode = {2'h0, buck_three_off_behaviour, 1'h0, buck_three_switch_mode};
    wire    [7:0] b2_conf = {1'h0, buck_two_scaling_rate, buck_two_phase_sel,
                             buck_two_freq_sel, 1'h0, buck_two_current_limit};
    wire    [7:0] b3_conf = {1'h0, buck_three_scaling_rate, buck_three_phase_sel,
                             buck_three_freq_sel, 1'h0, buck_three_current_limit};
    wire    [7:0] bst     = {1'h0, boost_standby_mode, 1'h0, boost_normal_mode, boost_voltage_sel};

    bbr_ctrl_regs DUT
    (
        .clk_sys, .reset, .clk_en, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .reg_rd_ack, .reg_addr_err, .otp_b2_mode(otp_v[0]), .otp_b2_conf(otp_v[1]),
        .otp_b3_volt(otp_v[2]), .otp_b3_stby(otp_v[3]), .otp_b3_slp(otp_v[4]),
        .otp_b3_mode(otp_v[5]), .otp_b3_conf(otp_v[6]), .otp_bst_ctl(otp_v[7]),
        .turn_off_evt, .turn_on_evt, .standby_req, .boost_seq_en, .boost_heavy_load,
        .buck_two_off_behaviour, .buck_two_switch_mode, .buck_two_scaling_rate,
        .buck_two_phase_sel, .buck_two_freq_sel, .buck_two_current_limit,
        .buck_three_off_behaviour, .buck_three_switch_mode, .buck_three_scaling_rate,
        .buck_three_phase_sel, .buck_three_freq_sel, .buck_three_current_limit,
        .buck_three_vcode, .buck_sleep, .buck_off, .dvs_step, .boost_standby_mode,
        .boost_normal_mode, .boost_voltage_sel, .boost_drive
    );

    bbr_host_model host
    (
        .clk_sys, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_ack,
        .reg_addr_err
    );

    function automatic logic [7:0] rnd8();
        repeat (8) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction : rnd8

    function automatic logic [2:0] drv_exp(input logic [7:0] b, input logic sb,
                                           input logic en, input logic hv);
        logic [1:0] m;
        m = sb ? b[6:5] : b[3:2];
        case (m)
            2'h0:    return 3'h1;
            2'h1:    return 3'h2;
            2'h2:    return !en ? 3'h1 : (hv ? 3'h4 : 3'h2);
            default: return 3'h4;
        endcase
    endfunction : drv_exp

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp

    task automatic chk_fields();
        cmp(b2_mode, sh[0], "b2 mode");
        cmp(b3_mode, sh[5], "b3 mode");
        cmp(b2_conf, sh[1], "b2 conf");
        cmp(b3_conf, sh[6], "b3 conf");
        cmp(bst, sh[7], "boost ctl");
    endtask : chk_fields

    task automatic rd_chk(input int i);
        host.rd(ofs[i], rd_d, rd_e, rd_k);
        cmp({rd_k, rd_e, 6'h0}, 8'h80, "rd flags");
        cmp(rd_d, sh[i], "rd data");
    endtask : rd_chk

    task automatic wr_sh(input int i, input logic [7:0] d);
        host.wr(ofs[i], d);
        sh[i] = d & msk[i];
        chk_fields();
        rd_chk(i);
    endtask : wr_sh

    task automatic pulse_off();
        turn_off_evt = 1'b1;
        @(negedge clk_sys);
        turn_off_evt = 1'b0;
    endtask : pulse_off

    task automatic step_gap(input int b);
        t = 0;
        do
        begin
            @(negedge clk_sys);
            t++;
        end
        while (dvs_step[b] !== 1'b1 && t < 200);
    endtask : step_gap

    // Bound covers a full 32-code ramp at the fast rate
    task automatic ramp(input logic [7:0] c);
        t = 0;
        while (buck_three_vcode !== c[4:0] && t < 1500)
        begin
            @(negedge clk_sys);
            t++;
        end
        cmp({3'h0, buck_three_vcode}, c, "vcode");
    endtask : ramp

    task automatic end_of_test();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test

    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    initial
    begin
        repeat (30000) @(posedge clk_sys);
        err_total++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_of_test();
    end

    initial
    begin
        {clk_en, reset} = 2'h3;
        {turn_off_evt, turn_on_evt, standby_req, boost_seq_en, boost_heavy_load} = 5'h00;
        seed = 32'hbffa_2e9a;
        foreach (otp_v[i]) otp_v[i] = rnd8();
        repeat (20) @(negedge clk_sys);
        reset = 1'b0;
        foreach (sh[i]) sh[i] = otp_v[i] & om[i];
        chk_fields();
        for (int i = 0; i < 8; i++) rd_chk(i);
        // all ones, all zeros, then random data
        for (int n = 0; n < 32; n++) wr_sh(n % 8, n < 8 ? 8'hFF : n < 16 ? 8'h00 : rnd8());
        host.wr(8'h3A, 8'hFF);
        chk_fields();
        host.rd(8'h3A, rd_d, rd_e, rd_k);
        cmp({rd_k, rd_e, 6'h0}, 8'hC0, "unmapped flags");
        cmp(rd_d, 8'h00, "unmapped data");
        // A write with the clock enable low must leave every field alone
        clk_en = 1'b0;
        host.wr(ofs[7], ~sh[7]);
        clk_en = 1'b1;
        chk_fields();
        // every mode code in both states
        for (int j = 0; j < 64; j++)
        begin
            {boost_seq_en, standby_req} = 2'(j >> 4);
            boost_heavy_load = seed[3];
            wr_sh(7, {1'b0, 2'(j >> 2), 1'b0, 2'(j), 2'(rnd8())});
            cmp({5'h0, boost_drive}, {5'h0, drv_exp(sh[7], standby_req, boost_seq_en,
                boost_heavy_load)}, "boost drive");
        end
        for (int k = 0; k < 4; k++)
        begin
            wr_sh(0, {sh[0][7:6], k[0], sh[0][4:0]});
            wr_sh(5, {sh[5][7:6], k[1], sh[5][4:0]});
            pulse_off();
            cmp({4'h0, buck_sleep, buck_off}, {4'h0, 2'(k), ~2'(k)}, "off state");
            turn_on_evt = 1'b1;
            @(negedge clk_sys);
            turn_on_evt = 1'b0;
            cmp({4'h0, buck_sleep, buck_off}, 8'h00, "on state");
        end
        for (int r = 0; r < 2; r++)
        begin
            wr_sh(1, {sh[1][7], r[0], sh[1][5:0]});
            wr_sh(6, {sh[6][7], r[0], sh[6][5:0]});
            for (int b = 0; b < 2; b++)
            begin
                repeat (3) step_gap(b);
                cmp(8'(t), r ? 8'h50 : 8'h28, "step gap");
            end
        end
        // ramp to normal, standby and sleep codes
        wr_sh(6, sh[6] & 8'hBF);
        // Boost sweep leaves standby high; normal target needs it low
        standby_req = 1'b0;
        wr_sh(2, rnd8());
        ramp(sh[2]);
        wr_sh(3, sh[2] ^ 8'h15);
        standby_req = 1'b1;
        ramp(sh[3]);
        wr_sh(5, sh[5] | 8'h20);
        wr_sh(4, sh[3] ^ 8'h0A);
        pulse_off();
        ramp(sh[4]);
        end_of_test();
    end
endmodule : test_buck_boost_regulator_ctrl_regs
